// [bench/etws_master_model.sv]
`timescale 1ns/1ps
// Bus master: pulls low or releases, clock stands high between frames
module etws_master_model (
	// Wire level seen on the bus
	input wire logic i_sda,
	// Clock and open-drain pull
	output logic o_scl,
	output logic o_sda_low
);
	localparam int Q = 80;
	initial begin
		o_scl = 1'b1;
		o_sda_low = 1'b0;
	end
	task automatic start();
		#Q o_sda_low = 1'b0;
		#Q o_scl = 1'b1;
		#Q o_sda_low = 1'b1;
		#(4*Q) o_scl = 1'b0;
	endtask
	task automatic stop();
		#Q o_sda_low = 1'b1;
		#Q o_scl = 1'b1;
		#Q o_sda_low = 1'b0;
		#(4*Q);
	endtask
	// Data set only while clock low
	task automatic bit_io(input logic b, output logic s);
		#Q o_sda_low = ~b;
		#Q o_scl = 1'b1;
		#Q s = i_sda;
		#Q o_scl = 1'b0;
	endtask
	// MSB first, ninth clock samples the ack
	task automatic put(input logic [7:0] d, output logic ack);
		logic s;
		for (int i = 7; i >= 0; i--) bit_io(d[i], s);
		bit_io(1'b1, s);
		ack = ~s;
	endtask
	// Master acks when mack is set
	task automatic get(input logic mack, output logic [7:0] d);
		logic s;
		for (int i = 7; i >= 0; i--) bit_io(1'b1, d[i]);
		bit_io(~mack, s);
	endtask
	// Address, word, then n data bytes counting up
	task automatic wr(input logic [7:0] sa, w, d, input int n, output logic [7:0] ak);
		ak = '0;
		start();
		put(sa, ak[0]);
		put(w, ak[1]);
		for (int i = 0; i < n; i++) put(d + 8'(i), ak[i+2]);
		stop();
	endtask
endmodule // etws_master_model

// [bench/etws_slave_asserts.sv]
`timescale 1ns/1ps
// Pin-level watch on the slave, attached by bind
module etws_slave_asserts #(
	parameter ADDR_W = 11,
	parameter DATA_W = 8
) (
	// Clock and reset
	input wire i_clk,
	input wire i_rst_n,
	// Serial bus
	input wire i_scl,
	input wire i_sda,
	input wire o_sda_out,
	input wire o_sda_oe,
	// Array side
	input wire o_wr_valid,
	input wire [ADDR_W+DATA_W-1:0] o_wr_data,
	input wire i_wr_ready,
	input wire o_program_start,
	input wire o_rd_req,
	// Status
	input wire o_active,
	input wire o_read_mode
);
	default clocking cb @(posedge i_clk); endclocking
	default disable iff (!i_rst_n);
	////////////////////////////////////////////////////////////
	a_drive_low_only: assert property (o_sda_out == 1'b0)
		else $error("data pin value not low");
	a_idle_released: assert property (!o_active |-> !o_sda_oe)
		else $error("data pulled while idle");
	a_start_seen: assert property ($rose(o_active) |-> i_scl && !i_sda)
		else $error("active without start");
	a_prog_pulse: assert property (o_program_start |=> !o_program_start && !o_active)
		else $error("program pulse bad");
	a_read_select: assert property ($rose(o_read_mode) |-> o_active)
		else $error("read mode outside frame");
	a_rd_req_pulse: assert property (o_rd_req |=> !o_rd_req)
		else $error("read request too long");
	// Longest pull: ack plus eight zero bits, about 72 clocks
	a_pull_bounded: assert property ($rose(o_sda_oe) |-> ##[1:80] !o_sda_oe)
		else $error("data line held too long");
	// Stalled words must not move
	a_wr_hold: assert property (o_wr_valid && !i_wr_ready |=> o_wr_valid && $stable(o_wr_data))
		else $error("write word dropped");
endmodule // etws_slave_asserts

bind etws_slave etws_slave_asserts #(.ADDR_W(ADDR_W), .DATA_W(DATA_W)) etws_slave_asserts_i (
	.i_clk(i_clk), .i_rst_n(i_rst_n), .i_scl(i_scl), .i_sda(i_sda), .o_sda_out(o_sda_out),
	.o_sda_oe(o_sda_oe), .o_wr_valid(o_wr_valid), .o_wr_data(o_wr_data),
	.i_wr_ready(i_wr_ready), .o_program_start(o_program_start), .o_rd_req(o_rd_req),
	.o_active(o_active), .o_read_mode(o_read_mode));

// [bench/test_etws_slave.sv]
`timescale 1ns/1ps
module test_etws_slave;
	logic clk = 1'b0, rst_n = 1'b0, wp = 1'b0, busy = 1'b0, rdy = 1'b1;
	logic [7:0] rd_data = 8'h00;
	wire scl, sda_low, sda_oe, sda, wv, rq, ps, act, rm, sda_out;
	wire [18:0] wd;
	wire [10:0] ra;
	int fail_count = 0, tests_run = 0, cyc = 0, progs = 0;
	logic [18:0] got[$];
	// Pull-up wins unless someone pulls low
	assign sda = ~(sda_low | sda_oe);
	etws_slave etws_slave_i (.i_clk(clk), .i_rst_n(rst_n), .i_scl(scl), .i_sda(sda),
		.o_sda_out(sda_out), .o_sda_oe(sda_oe), .i_write_protect(wp), .o_wr_valid(wv),
		.o_wr_data(wd), .i_wr_ready(rdy), .o_program_start(ps), .i_write_busy(busy),
		.o_rd_req(rq), .o_rd_addr(ra), .i_rd_data(rd_data), .o_active(act), .o_read_mode(rm));
	etws_master_model etws_master_model_i (.i_sda(sda), .o_scl(scl), .o_sda_low(sda_low));
	////////////////////////////////////////////////////////////
	// 25 MHz system clock
	initial begin
		forever #20 clk = ~clk;
	end
	// Array stand-in: take words, count programs, answer reads
	always @(posedge clk) begin
		if (wv && rdy) got.push_back(wd);
		if (ps) progs++;
		if (rq) rd_data <= #1 ra[7:0] ^ {5'h0, ra[10:8]};
	end
	// Hang guard, well above the expected run
	always @(posedge clk) begin
		cyc++;
		if (cyc == 20000) begin
			fail_count++;
			finish_test();
		end
	end
	task automatic chk(input string n, input logic [18:0] e, input logic [18:0] g);
		tests_run++;
		if (g !== e) begin
			fail_count++;
			$display("Error %s expected %h seen %h", n, e, g);
		end
	endtask
	task automatic finish_test();
		$display("Checks %0d mismatches %0d", tests_run, fail_count);
		if (fail_count == 0 && tests_run > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask
	////////////////////////////////////////////////////////////
	// Every block, two bytes wrapping inside the page
	task automatic t_blocks();
		logic [7:0] ak;
		for (int b = 0; b < 8; b++) begin
			got.delete();
			etws_master_model_i.wr({4'ha, 3'(b), 1'b0}, 8'h0f, 8'(b), 2, ak);
			chk("acks", 19'h0f, 19'(ak));
			chk("word0", {3'(b), 8'h0f, 8'(b)}, got[0]);
			chk("word1", {3'(b), 8'h00, 8'(b + 1)}, got[1]);
		end
		chk("programs", 19'd8, 19'(progs));
	endtask
	// Protected upper block versus lower block
	task automatic t_protect();
		logic [7:0] ak;
		int p;
		@(posedge clk);
		#1 wp = 1'b1;
		p = progs;
		got.delete();
		etws_master_model_i.wr(8'hac, 8'h20, 8'h11, 1, ak);
		chk("prot acks", 19'h03, 19'(ak));
		chk("prot prog", 19'(p), 19'(progs));
		chk("prot words", 19'h0, 19'(got.size()));
		etws_master_model_i.wr(8'ha6, 8'h20, 8'h11, 1, ak);
		chk("low acks", 19'h07, 19'(ak));
		chk("low prog", 19'(p + 1), 19'(progs));
		@(posedge clk);
		#1 wp = 1'b0;
	endtask
	// Wrong type, then a matching byte with no start
	task automatic t_nomatch();
		logic [7:0] ak;
		etws_master_model_i.wr(8'h20, 8'ha0, 8'h55, 1, ak);
		chk("mismatch acks", 19'h0, 19'(ak));
	endtask
	// Write cycle running: address refused
	task automatic t_busy();
		logic [7:0] ak;
		@(posedge clk);
		#1 busy = 1'b1;
		etws_master_model_i.wr(8'ha0, 8'h00, 8'h00, 1, ak);
		chk("busy acks", 19'h0, 19'(ak));
		@(posedge clk);
		#1 busy = 1'b0;
	endtask
	// Stalled array: four words fit, the fifth is refused
	task automatic t_fifo();
		logic [7:0] ak;
		got.delete();
		@(posedge clk);
		#1 rdy = 1'b0;
		etws_master_model_i.wr(8'ha0, 8'h40, 8'h30, 5, ak);
		chk("full acks", 19'h3f, 19'(ak));
		@(posedge clk);
		#1 rdy = 1'b1;
		repeat (8) @(posedge clk);
		// Keep the next frame's pin changes off the clock edge
		#1;
		chk("drained", 19'h4, 19'(got.size()));
		chk("last word", {3'h0, 8'h43, 8'h33}, got[3]);
	endtask
	// Random read crossing a block, ack then no ack
	task automatic t_read();
		logic a0, a1, a2;
		logic [7:0] d0, d1, d2;
		etws_master_model_i.start();
		etws_master_model_i.put(8'ha4, a0);
		etws_master_model_i.put(8'hff, a1);
		etws_master_model_i.start();
		etws_master_model_i.put(8'ha5, a2);
		chk("rd acks", 19'h7, 19'({a2, a1, a0}));
		chk("rd mode", 19'h1, 19'(rm));
		etws_master_model_i.get(1'b1, d0);
		etws_master_model_i.get(1'b0, d1);
		etws_master_model_i.get(1'b1, d2);
		etws_master_model_i.stop();
		chk("rd0", 19'hfd, 19'(d0));
		chk("rd1", 19'h03, 19'(d1));
		chk("rd after nack", 19'hff, 19'(d2));
		chk("end idle", 19'h0, 19'({act, rm}));
	endtask
	// Main sequence
	initial begin
		repeat (12) @(posedge clk);
		#1 rst_n = 1'b1;
		repeat (4) @(posedge clk);
		// Master delays are whole clock multiples, so start off the edge
		#1;
		t_blocks();
		t_protect();
		t_nomatch();
		t_busy();
		t_fifo();
		t_read();
		finish_test();
	end
endmodule // test_etws_slave

// [rtl/etws_defines.vh]
`ifndef ETWS_DEFINES_VH
`define ETWS_DEFINES_VH
// Device type code in the top nibble of the slave address
`define ETWS_DEV_TYPE 4'ha
// Slave address field positions
`define ETWS_TYPE_MSB 7
`define ETWS_TYPE_LSB 4
`define ETWS_BLK_MSB 3
`define ETWS_BLK_LSB 1
`define ETWS_RW_BIT 0
// Upper half of the array: page blocks 4..7, block bit two set
`define ETWS_PROT_BIT 2
// Array geometry
`define ETWS_ADDR_W 11
`define ETWS_DATA_W 8
`define ETWS_FIFO_DEPTH 4
// Bits per byte before the acknowledge slot
`define ETWS_BITS_PER_BYTE 4'h8
`endif

// [rtl/etws_fifo.v]
`timescale 1ns/1ps
// Small synchronous FIFO with valid/ready on both sides
module etws_fifo #(
	parameter WIDTH = 19,
	parameter DEPTH = 4,
	parameter AW = 2
) (
	// Clock and reset
	input wire i_clk,
	input wire i_rst_n,
	// Fill side
	input wire i_in_valid,
	input wire [WIDTH-1:0] i_in_data,
	output wire o_in_ready,
	// Drain side
	output wire o_out_valid,
	output wire [WIDTH-1:0] o_out_data,
	input wire i_out_ready
);
	reg [WIDTH-1:0] mem [0:DEPTH-1];
	reg [AW-1:0] wr_ptr_reg;
	reg [AW-1:0] rd_ptr_reg;
	reg [AW:0] count_reg;
	wire push;
	wire pop;

	// Honest full and empty from the occupancy count
	assign o_in_ready = (count_reg != DEPTH[AW:0]);
	assign o_out_valid = (count_reg != {(AW+1){1'b0}});
	assign o_out_data = mem[rd_ptr_reg];
	assign push = i_in_valid & o_in_ready;
	assign pop = o_out_valid & i_out_ready;

	// Storage write, no reset needed on data
	always @(posedge i_clk) begin
		if (push) begin
			mem[wr_ptr_reg] <= i_in_data;
		end
	end

	// Pointers wrap at the depth
	always @(posedge i_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			wr_ptr_reg <= {AW{1'b0}};
			rd_ptr_reg <= {AW{1'b0}};
			count_reg <= {(AW+1){1'b0}};
		end else begin
			if (push) begin
				wr_ptr_reg <= (wr_ptr_reg == DEPTH[AW-1:0] - 1'b1) ? {AW{1'b0}} :
					wr_ptr_reg + 1'b1;
			end
			if (pop) begin
				rd_ptr_reg <= (rd_ptr_reg == DEPTH[AW-1:0] - 1'b1) ? {AW{1'b0}} :
					rd_ptr_reg + 1'b1;
			end
			if (push && !pop) begin
				count_reg <= count_reg + 1'b1;
			end else if (pop && !push) begin
				count_reg <= count_reg - 1'b1;
			end
		end
	end
endmodule // etws_fifo

// [rtl/etws_slave.v]
`timescale 1ns/1ps
`include "etws_defines.vh"
module etws_slave #(
	parameter ADDR_W = `ETWS_ADDR_W,
	parameter DATA_W = `ETWS_DATA_W,
	parameter FIFO_DEPTH = `ETWS_FIFO_DEPTH
) (
	// Clock and reset
	input wire i_clk,
	input wire i_rst_n,
	// Serial bus pins, data line open-drain
	input wire i_scl,
	input wire i_sda,
	output wire o_sda_out,
	output wire o_sda_oe,
	// Write protect pin, sampled as a plain level
	input wire i_write_protect,
	// Array side: write stream out through the FIFO
	output wire o_wr_valid,
	output wire [ADDR_W+DATA_W-1:0] o_wr_data,
	input wire i_wr_ready,
	// Array side: program request at the closing stop
	output reg o_program_start,
	input wire i_write_busy,
	// Array side: read byte request and answer
	output reg o_rd_req,
	output reg [ADDR_W-1:0] o_rd_addr,
	input wire [DATA_W-1:0] i_rd_data,
	// Status
	output reg o_active,
	output reg o_read_mode
);
	////////////////////////////////////////////////////////////////////
	// States, one-hot
	localparam [6:0] ST_IDLE = 7'h01;
	localparam [6:0] ST_ADDR = 7'h02;
	localparam [6:0] ST_WORD = 7'h04;
	localparam [6:0] ST_DATA = 7'h08;
	localparam [6:0] ST_TX = 7'h10;
	localparam [6:0] ST_ACK = 7'h20;
	localparam [6:0] ST_WAIT = 7'h40;

	// Slave address check against the fixed device type
	function addr_match;
		input [7:0] b;
		begin
			addr_match = (b[`ETWS_TYPE_MSB:`ETWS_TYPE_LSB] == `ETWS_DEV_TYPE);
		end
	endfunction

	// Location is in the upper half when block bit two is set
	function in_upper;
		input [ADDR_W-1:0] a;
		begin
			in_upper = a[ADDR_W-1];
		end
	endfunction

	////////////////////////////////////////////////////////////////////
	// Pin synchronisers
	wire scl_s;
	wire sda_s;
	wire wp_s;

	etws_sync u_sync_scl (
		.i_clk(i_clk),
		.i_rst_n(i_rst_n),
		.i_async(i_scl),
		.o_sync(scl_s)
	);
	etws_sync u_sync_sda (
		.i_clk(i_clk),
		.i_rst_n(i_rst_n),
		.i_async(i_sda),
		.o_sync(sda_s)
	);
	// undriven pin reads low: reset value zero below
	reg wp_meta_reg;
	reg wp_reg;
	always @(posedge i_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			wp_meta_reg <= 1'b0;
			wp_reg <= 1'b0;
		end else begin
			wp_meta_reg <= i_write_protect;
			wp_reg <= wp_meta_reg;
		end
	end
	assign wp_s = wp_reg;

	////////////////////////////////////////////////////////////////////
	// Edge detection on the synchronised lines
	reg scl_d_reg;
	reg sda_d_reg;
	always @(posedge i_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			scl_d_reg <= 1'b1;
			sda_d_reg <= 1'b1;
		end else begin
			scl_d_reg <= scl_s;
			sda_d_reg <= sda_s;
		end
	end

	wire scl_rise = scl_s & ~scl_d_reg;
	wire scl_fall = ~scl_s & scl_d_reg;
	// data edges with clock high are conditions only
	wire start_det = scl_s & scl_d_reg & sda_d_reg & ~sda_s;
	wire stop_det = scl_s & scl_d_reg & ~sda_d_reg & sda_s;

	////////////////////////////////////////////////////////////////////
	// Protocol state
	reg [6:0] state_reg;
	reg [6:0] ret_reg;
	reg [3:0] bit_cnt_reg;
	reg [7:0] shift_reg;
	reg [ADDR_W-1:0] addr_reg;
	reg [2:0] blk_reg;
	reg ack_drive_reg;
	reg tx_bit_reg;
	reg pend_prog_reg;
	reg in_valid_reg;
	reg [ADDR_W+DATA_W-1:0] in_data_reg;
	wire in_ready;

	// only ever pulls low; enable high means drive zero
	assign o_sda_out = 1'b0;
	assign o_sda_oe = ack_drive_reg | ~tx_bit_reg;

	// FIFO decouples byte capture from a slow array write port.
	// A full FIFO makes the byte go unacknowledged, so the master sees it.
	etws_fifo #(
		.WIDTH(ADDR_W+DATA_W),
		.DEPTH(FIFO_DEPTH),
		.AW(2)
	) u_fifo (
		.i_clk(i_clk),
		.i_rst_n(i_rst_n),
		.i_in_valid(in_valid_reg),
		.i_in_data(in_data_reg),
		.o_in_ready(in_ready),
		.o_out_valid(o_wr_valid),
		.o_out_data(o_wr_data),
		.i_out_ready(i_wr_ready)
	);

	// Main sequencer, clocked by the system clock, bus clock edges as events
	always @(posedge i_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			state_reg <= ST_IDLE;
			ret_reg <= ST_IDLE;
			bit_cnt_reg <= 4'h0;
			shift_reg <= 8'h00;
			addr_reg <= {ADDR_W{1'b0}};
			blk_reg <= 3'h0;
			ack_drive_reg <= 1'b0;
			tx_bit_reg <= 1'b1;
			pend_prog_reg <= 1'b0;
			in_valid_reg <= 1'b0;
			in_data_reg <= {(ADDR_W+DATA_W){1'b0}};
			o_program_start <= 1'b0;
			o_rd_req <= 1'b0;
			o_rd_addr <= {ADDR_W{1'b0}};
			o_active <= 1'b0;
			o_read_mode <= 1'b0;
		end else begin
			o_program_start <= 1'b0;
			o_rd_req <= 1'b0;
			if (in_valid_reg && in_ready) begin
				in_valid_reg <= 1'b0;
			end
			if (start_det) begin
				state_reg <= ST_ADDR;
				bit_cnt_reg <= 4'h0;
				ack_drive_reg <= 1'b0;
				tx_bit_reg <= 1'b1;
				o_active <= 1'b1;
			end else if (stop_det) begin
				// write goes to programming, else standby
				if (pend_prog_reg) begin
					o_program_start <= 1'b1;
				end
				pend_prog_reg <= 1'b0;
				state_reg <= ST_IDLE;
				ack_drive_reg <= 1'b0;
				tx_bit_reg <= 1'b1;
				o_active <= 1'b0;
				o_read_mode <= 1'b0;
			end else begin
				case (state_reg)
				ST_IDLE, ST_WAIT: begin
					ack_drive_reg <= 1'b0;
					tx_bit_reg <= 1'b1;
				end
				ST_ADDR, ST_WORD, ST_DATA: begin
					if (scl_rise) begin
						shift_reg <= {shift_reg[6:0], sda_s};
						bit_cnt_reg <= bit_cnt_reg + 4'h1;
					end else if (scl_fall && bit_cnt_reg == `ETWS_BITS_PER_BYTE) begin
						bit_cnt_reg <= 4'h0;
						state_reg <= ST_ACK;
						ret_reg <= ST_WAIT;
						if (state_reg == ST_ADDR) begin
							if (addr_match(shift_reg) && !i_write_busy) begin
								ack_drive_reg <= 1'b1;
								// all three bits are block bits
								blk_reg <= shift_reg[`ETWS_BLK_MSB:`ETWS_BLK_LSB];
								if (shift_reg[`ETWS_RW_BIT]) begin
									ret_reg <= ST_TX;
									o_read_mode <= 1'b1;
									o_rd_req <= 1'b1;
									o_rd_addr <= addr_reg;
								end else begin
									ret_reg <= ST_WORD;
									o_read_mode <= 1'b0;
								end
							end
						end else if (state_reg == ST_WORD) begin
							addr_reg <= {blk_reg, shift_reg};
							ack_drive_reg <= 1'b1;
							ret_reg <= ST_DATA;
						end else begin
							if (!(wp_s && in_upper(addr_reg)) && in_ready) begin
								ack_drive_reg <= 1'b1;
								in_valid_reg <= 1'b1;
								in_data_reg <= {addr_reg, shift_reg};
								pend_prog_reg <= 1'b1;
								addr_reg <= {addr_reg[ADDR_W-1:4], addr_reg[3:0] + 4'h1};
								ret_reg <= ST_DATA;
							end
						end
					end
				end
				ST_ACK: begin
					// hold ack through ninth clock, release on its fall
					if (scl_fall) begin
						ack_drive_reg <= 1'b0;
						state_reg <= ret_reg;
						bit_cnt_reg <= 4'h0;
						if (ret_reg == ST_TX) begin
							shift_reg <= i_rd_data;
							tx_bit_reg <= i_rd_data[7];
							addr_reg <= addr_reg + 1'b1;
						end
					end
				end
				ST_TX: begin
					// shift out on clock falls, release for ninth
					if (scl_rise) begin
						bit_cnt_reg <= bit_cnt_reg + 4'h1;
						if (bit_cnt_reg == `ETWS_BITS_PER_BYTE) begin
							if (sda_s) begin
								// no ack: release and wait for stop
								state_reg <= ST_WAIT;
							end else begin
								o_rd_req <= 1'b1;
								o_rd_addr <= addr_reg;
							end
						end
					end else if (scl_fall) begin
						// Eighth fall ends bit zero, so let go for the ack slot
						if (bit_cnt_reg == `ETWS_BITS_PER_BYTE) begin
							tx_bit_reg <= 1'b1;
						end else if (bit_cnt_reg == `ETWS_BITS_PER_BYTE + 4'h1) begin
							bit_cnt_reg <= 4'h0;
							shift_reg <= i_rd_data;
							tx_bit_reg <= i_rd_data[7];
							addr_reg <= addr_reg + 1'b1;
						end else begin
							shift_reg <= {shift_reg[6:0], 1'b1};
							tx_bit_reg <= shift_reg[6];
						end
					end
				end
				default: begin
					state_reg <= ST_IDLE;
				end
				endcase
			end
		end
	end
endmodule // etws_slave

// [rtl/etws_sync.v]
`timescale 1ns/1ps
// Two-stage synchroniser for pins from outside the clock domain
module etws_sync (
	// Clock and reset
	input wire i_clk,
	input wire i_rst_n,
	// Asynchronous level in, synchronised level out
	input wire i_async,
	output wire o_sync
);
	reg meta_reg;
	reg sync_reg;

	// First stage is read only by the second stage
	always @(posedge i_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			meta_reg <= 1'b1;
			sync_reg <= 1'b1;
		end else begin
			meta_reg <= i_async;
			sync_reg <= meta_reg;
		end
	end

	assign o_sync = sync_reg;
endmodule // etws_sync
